// ### pkg/i2crb_pkg.sv
// Purpose: shared constants and types of the two-wire slave with its 32-byte buffer
// Assumes: 40 MHz system clock, bus master drives SCL, open-drain pins resolved outside
// Notes: times are in ns and turned into cycle counts here
package i2crb_pkg;

  // system clock period, 25 ns
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_0019;
  // data setup before SCL is let go after a stretch, 250 ns
  localparam int unsigned T_SU_DAT_NS   = 32'h0000_00FA;
  localparam int unsigned SU_CYC        = (T_SU_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SU_LOAD       = 4'(SU_CYC);
  localparam logic [3:0]  SU_IDLE       = 4'h0;

  // buffer geometry: 32 bytes, 5 address bits
  localparam int unsigned BUF_DEPTH     = 32'h0000_0020;
  localparam int unsigned BUF_AW        = 32'h0000_0005;
  localparam logic [7:0]  PTR_MAX       = 8'h1F;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [4:0]  BASE_RST      = 5'h00;
  localparam logic [5:0]  CUR_RST       = 6'h00;

  // bit counting within a byte
  localparam logic [3:0]  CNT_RST       = 4'h0;
  localparam logic [3:0]  LAST_RX_BIT   = 4'h7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // phases of the ninth bit
  localparam logic [1:0]  PH_WAIT_FALL  = 2'h0;
  localparam logic [1:0]  PH_DRIVE      = 2'h1;
  localparam logic [1:0]  PH_RELEASE    = 2'h2;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_RX       = 8'h02,
    ST_STALL_RX = 8'h04,
    ST_ACK      = 8'h08,
    ST_TX       = 8'h10,
    ST_TX_ACK   = 8'h20,
    ST_STALL_TX = 8'h40,
    ST_IGNORE   = 8'h80
  } i2crb_state_type;

endpackage : i2crb_pkg

// ### pkg/i2crb_mem_if.sv
// Purpose: buffer access signals between the protocol engine and the buffer memory
// Assumes: one master port and one processor port
// Notes: ctl is the requesting side, mem the storage side
`timescale 1ns/1ps
interface i2crb_mem_if #(
  parameter int unsigned AW = i2crb_pkg::BUF_AW
);
  logic          m_req;
  logic          m_we;
  logic [AW-1:0] m_addr;
  logic [7:0]    m_wdata;
  logic [7:0]    m_rdata;
  logic          c_req;
  logic          c_we;
  logic [AW-1:0] c_addr;
  logic [7:0]    c_wdata;
  logic [7:0]    c_rdata;
  logic          c_done;
  logic          c_ready;

  modport ctl (
    output m_req, m_we, m_addr, m_wdata, c_req, c_we, c_addr, c_wdata,
    input  m_rdata, c_rdata, c_done, c_ready
  );
  modport mem (
    input  m_req, m_we, m_addr, m_wdata, c_req, c_we, c_addr, c_wdata,
    output m_rdata, c_rdata, c_done, c_ready
  );
endinterface : i2crb_mem_if

// ### hdl/i2crb_line_mon.sv
// Purpose: synchronise SCL and SDA and find edges, Start and Stop
// Assumes: pins are asynchronous to the system clock
// Notes: edge, Start and Stop outputs are pulses one system cycle long, o_scl and o_sda are levels
`timescale 1ns/1ps
module i2crb_line_mon (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop
);
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  // two-flop synchronisers plus one history stage, idle bus reads high
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= i_sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // a few cycles of latency against a 1.25 us half period at 400 kHz
  assign o_scl      = scl_s_q;
  assign o_sda      = sda_s_q;
  assign o_scl_rise = scl_s_q & ~scl_p_q;
  assign o_scl_fall = ~scl_s_q & scl_p_q;
  // sda moving while scl stays high frames a transfer
  assign o_start    = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign o_stop     = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

endmodule : i2crb_line_mon

// ### hdl/i2crb_ram.sv
// Purpose: 32-byte buffer shared by the bus master and the processor
// Assumes: master requests are many cycles apart
// Notes: master wins a shared cycle, processor request waits one cycle in a holding slot
`timescale 1ns/1ps
module i2crb_ram #(
  parameter int unsigned DEPTH = i2crb_pkg::BUF_DEPTH
) (
  input  wire logic  i_clk_sys,
  input  wire logic  i_sys_rst,
  i2crb_mem_if.mem   mif
);
  logic [7:0]            mem_q [DEPTH];
  logic                  pend_q;
  logic                  pend_we_q;
  logic [$bits(mif.c_addr)-1:0] pend_addr_q;
  logic [7:0]            pend_wdata_q;
  logic                  cpu_go;
  logic                  cpu_we;
  logic [$bits(mif.c_addr)-1:0] cpu_addr;
  logic [7:0]            cpu_wdata;

  // processor side takes the held request first, then a live one
  assign cpu_go      = (pend_q | mif.c_req) & ~mif.m_req;
  assign cpu_we      = pend_q ? pend_we_q : mif.c_we;
  assign cpu_addr    = pend_q ? pend_addr_q : mif.c_addr;
  assign cpu_wdata   = pend_q ? pend_wdata_q : mif.c_wdata;
  assign mif.c_ready = ~pend_q;

  // holding slot for a processor request that met a master request
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_q       <= 1'b0;
      pend_we_q    <= 1'b0;
      pend_addr_q  <= '0;
      pend_wdata_q <= i2crb_pkg::BYTE_RST;
    end else if (mif.m_req && mif.c_req && !pend_q) begin
      pend_q       <= 1'b1;
      pend_we_q    <= mif.c_we;
      pend_addr_q  <= mif.c_addr;
      pend_wdata_q <= mif.c_wdata;
    end else if (cpu_go) begin
      pend_q       <= 1'b0;
    end
  end

  // single storage port, one access per cycle
  always_ff @(posedge i_clk_sys) begin
    if (mif.m_req && mif.m_we) begin
      mem_q[mif.m_addr] <= mif.m_wdata;
    end else if (cpu_go && cpu_we) begin
      mem_q[cpu_addr] <= cpu_wdata;
    end
  end

  // registered read data and completion pulse
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mif.m_rdata <= i2crb_pkg::BYTE_RST;
      mif.c_rdata <= i2crb_pkg::BYTE_RST;
      mif.c_done  <= 1'b0;
    end else begin
      mif.c_done <= cpu_go;
      if (mif.m_req && !mif.m_we) begin
        mif.m_rdata <= mem_q[mif.m_addr];
      end
      if (cpu_go && !cpu_we) begin
        mif.c_rdata <= mem_q[cpu_addr];
      end
    end
  end

endmodule : i2crb_ram

// ### hdl/i2crb_slave.sv
// Purpose: two-wire slave with compatible stall mode and 32-byte buffered mode
// Assumes: SCL and SDA are open drain, driven low while the matching enable is high
// Notes: processor handshakes are single-cycle pulses on the system clock
`timescale 1ns/1ps
module i2crb_slave (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  output logic            o_pins_claimed,
  input  wire logic       i_enable,
  input  wire logic       i_ram_buffer_mode,
  input  wire logic       i_hw_address_compare_enable,
  input  wire logic       i_sleep,
  input  wire logic [6:0] i_slave_address,
  output logic            o_byte_complete,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_is_address,
  output logic            o_stalled,
  output logic            o_dir,
  output logic            o_slave_busy,
  input  wire logic       i_cpu_release,
  input  wire logic       i_cpu_nack,
  input  wire logic [7:0] i_cpu_tx_data,
  input  wire logic       i_cpu_base_wr,
  input  wire logic [4:0] i_cpu_base_pointer,
  input  wire logic       i_cpu_buf_wr,
  input  wire logic       i_cpu_buf_rd,
  input  wire logic [7:0] i_cpu_buf_wdata,
  output logic [7:0]      o_cpu_buf_rdata,
  output logic            o_cpu_buf_done,
  output logic            o_cpu_buf_ready
);
  i2crb_mem_if mif ();

  i2crb_pkg::i2crb_state_type state_q;
  logic       scl_s;
  logic       sda_s;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] su_cnt_q;
  logic [1:0] ph_q;
  logic       is_addr_q;
  logic       dir_q;
  logic       ack_q;
  logic       first_q;
  logic       sda_low_q;
  logic       seen_low_q;
  logic       busy_q;
  logic       bc_q;
  logic       oor_q;
  logic [4:0] base_q;
  logic [5:0] cur_q;
  logic [4:0] cpu_cur_q;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic       addr_done;
  logic       addr_match;
  logic       mst_ack;
  logic       fetch_addr;
  logic       fetch_next;
  logic       store_byte;
  logic       cpu_access;
  logic       sleep_hold;
  logic [7:0] tx_next;

  i2crb_line_mon u_line_mon (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_scl      (scl_s),
    .o_sda      (sda_s),
    .o_scl_rise (rise),
    .o_scl_fall (fall),
    .o_start    (start),
    .o_stop     (stop)
  );

  i2crb_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .mif       (mif)
  );

  // next byte to put on the bus: buffer data, filler when out of range, or processor data
  function automatic logic [7:0] tx_pick(input logic ram, input logic oor,
                                         input logic [7:0] mem, input logic [7:0] cpu);
    if (!ram) begin
      tx_pick = cpu;
    end else if (oor) begin
      tx_pick = i2crb_pkg::FILL_BYTE;
    end else begin
      tx_pick = mem;
    end
  endfunction : tx_pick

  // events decoded from the protocol state
  assign rx_byte    = {shift_q[6:0], sda_s};
  assign byte_done  = (state_q == i2crb_pkg::ST_RX) && rise && !start && !stop
                      && (bit_cnt_q == i2crb_pkg::LAST_RX_BIT) && i_enable;
  assign addr_done  = byte_done && is_addr_q;
  assign addr_match = (rx_byte[7:1] == i_slave_address);
  assign mst_ack    = (state_q == i2crb_pkg::ST_TX_ACK) && rise && !sda_s && i_enable;
  assign fetch_addr = addr_done && rx_byte[0] && i_ram_buffer_mode
                      && (!i_hw_address_compare_enable || addr_match);
  assign fetch_next = mst_ack && i_ram_buffer_mode;
  assign store_byte = byte_done && !is_addr_q && i_ram_buffer_mode && !first_q && !cur_q[5];
  assign sleep_hold = i_ram_buffer_mode && i_sleep && !scl_s
                      && (state_q != i2crb_pkg::ST_IDLE) && (state_q != i2crb_pkg::ST_IGNORE);
  // byte to load for the next transmit, a bit select on a call result is not legal
  assign tx_next    = tx_pick(i_ram_buffer_mode, oor_q, mif.m_rdata, tx_q);

  // pins: open drain, only low is ever driven, claimed while enabled
  assign o_pins_claimed = i_enable;
  assign o_scl_o        = 1'b0;
  assign o_sda_o        = 1'b0;
  assign o_sda_oe       = sda_low_q && i_enable;
  assign o_scl_oe       = i_enable && ((seen_low_q && ((state_q == i2crb_pkg::ST_STALL_RX)
                          || (state_q == i2crb_pkg::ST_STALL_TX)))
                          || (su_cnt_q != i2crb_pkg::SU_IDLE) || sleep_hold);
  assign o_stalled      = (state_q == i2crb_pkg::ST_STALL_RX)
                          || (state_q == i2crb_pkg::ST_STALL_TX);
  assign o_dir          = dir_q;
  assign o_slave_busy   = busy_q;
  assign o_byte_complete = bc_q;

  // protocol engine
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q    <= i2crb_pkg::ST_IDLE;
      shift_q    <= i2crb_pkg::BYTE_RST;
      tx_q       <= i2crb_pkg::BYTE_RST;
      o_rx_data  <= i2crb_pkg::BYTE_RST;
      bit_cnt_q  <= i2crb_pkg::CNT_RST;
      su_cnt_q   <= i2crb_pkg::SU_IDLE;
      ph_q       <= i2crb_pkg::PH_WAIT_FALL;
      is_addr_q  <= 1'b0;
      o_rx_is_address <= 1'b0;
      dir_q      <= 1'b0;
      ack_q      <= 1'b0;
      first_q    <= 1'b0;
      sda_low_q  <= 1'b0;
      seen_low_q <= 1'b0;
    end else if (!i_enable) begin
      state_q    <= i2crb_pkg::ST_IDLE;
      sda_low_q  <= 1'b0;
      seen_low_q <= 1'b0;
      su_cnt_q   <= i2crb_pkg::SU_IDLE;
    end else if (start) begin
      state_q    <= i2crb_pkg::ST_RX;
      bit_cnt_q  <= i2crb_pkg::CNT_RST;
      is_addr_q  <= 1'b1;
      sda_low_q  <= 1'b0;
      seen_low_q <= 1'b0;
      su_cnt_q   <= i2crb_pkg::SU_IDLE;
    end else if (stop) begin
      state_q    <= i2crb_pkg::ST_IDLE;
      sda_low_q  <= 1'b0;
      seen_low_q <= 1'b0;
      su_cnt_q   <= i2crb_pkg::SU_IDLE;
    end else begin
      if (su_cnt_q != i2crb_pkg::SU_IDLE) begin
        su_cnt_q <= su_cnt_q - 4'h1;
      end
      case (state_q)
        i2crb_pkg::ST_IDLE: begin
        end
        i2crb_pkg::ST_RX: begin
          if (rise) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (byte_done) begin
            o_rx_data       <= rx_byte;
            o_rx_is_address <= is_addr_q;
            ph_q            <= i2crb_pkg::PH_WAIT_FALL;
            if (is_addr_q) begin
              dir_q   <= rx_byte[0];
              first_q <= !rx_byte[0];
              if (!i_hw_address_compare_enable) begin
                state_q <= i2crb_pkg::ST_STALL_RX;
              end else if (addr_match) begin
                ack_q   <= 1'b1;
                state_q <= i2crb_pkg::ST_ACK;
              end else begin
                state_q <= i2crb_pkg::ST_IGNORE;
              end
            end else if (i_ram_buffer_mode) begin
              ack_q   <= !(first_q && (rx_byte > i2crb_pkg::PTR_MAX));
              first_q <= 1'b0;
              state_q <= i2crb_pkg::ST_ACK;
            end else begin
              state_q <= i2crb_pkg::ST_STALL_RX;
            end
          end
        end
        i2crb_pkg::ST_STALL_RX: begin
          if (fall) begin
            seen_low_q <= 1'b1;
          end
          if (i_cpu_release) begin
            ack_q      <= !i_cpu_nack;
            tx_q       <= i_cpu_tx_data;
            seen_low_q <= 1'b0;
            state_q    <= i2crb_pkg::ST_ACK;
            if (seen_low_q || fall) begin
              sda_low_q <= !i_cpu_nack;
              su_cnt_q  <= i2crb_pkg::SU_LOAD;
              ph_q      <= i2crb_pkg::PH_DRIVE;
            end
          end
        end
        i2crb_pkg::ST_ACK: begin
          if (ph_q == i2crb_pkg::PH_WAIT_FALL && fall) begin
            sda_low_q <= ack_q;
            ph_q      <= i2crb_pkg::PH_DRIVE;
          end else if (ph_q == i2crb_pkg::PH_DRIVE && rise) begin
            ph_q      <= i2crb_pkg::PH_RELEASE;
          end else if (ph_q == i2crb_pkg::PH_RELEASE && fall) begin
            bit_cnt_q <= i2crb_pkg::CNT_RST;
            if (!ack_q) begin
              sda_low_q <= 1'b0;
              state_q   <= i2crb_pkg::ST_IGNORE;
            end else if (dir_q) begin
              tx_q      <= tx_next;
              sda_low_q <= !tx_next[7];
              state_q   <= i2crb_pkg::ST_TX;
            end else begin
              sda_low_q <= 1'b0;
              is_addr_q <= 1'b0;
              state_q   <= i2crb_pkg::ST_RX;
            end
          end
        end
        i2crb_pkg::ST_TX: begin
          if (rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (fall && bit_cnt_q == i2crb_pkg::BITS_PER_BYTE) begin
            sda_low_q <= 1'b0;
            ph_q      <= i2crb_pkg::PH_WAIT_FALL;
            state_q   <= i2crb_pkg::ST_TX_ACK;
          end else if (fall) begin
            tx_q      <= {tx_q[6:0], 1'b0};
            sda_low_q <= !tx_q[6];
          end
        end
        i2crb_pkg::ST_TX_ACK: begin
          if (rise && sda_s) begin
            state_q <= i2crb_pkg::ST_IGNORE;
          end else if (mst_ack) begin
            if (i_ram_buffer_mode) begin
              ph_q    <= i2crb_pkg::PH_RELEASE;
            end else begin
              state_q <= i2crb_pkg::ST_STALL_TX;
            end
          end else if (fall && ph_q == i2crb_pkg::PH_RELEASE) begin
            tx_q      <= tx_next;
            sda_low_q <= !tx_next[7];
            bit_cnt_q <= i2crb_pkg::CNT_RST;
            state_q   <= i2crb_pkg::ST_TX;
          end
        end
        i2crb_pkg::ST_STALL_TX: begin
          if (fall) begin
            seen_low_q <= 1'b1;
          end
          if (i_cpu_release) begin
            tx_q       <= i_cpu_tx_data;
            seen_low_q <= 1'b0;
            bit_cnt_q  <= i2crb_pkg::CNT_RST;
            if (seen_low_q || fall) begin
              sda_low_q <= !i_cpu_tx_data[7];
              su_cnt_q  <= i2crb_pkg::SU_LOAD;
              state_q   <= i2crb_pkg::ST_TX;
            end else begin
              ph_q      <= i2crb_pkg::PH_RELEASE;
              state_q   <= i2crb_pkg::ST_TX_ACK;
            end
          end
        end
        i2crb_pkg::ST_IGNORE: begin
        end
        default: begin
          state_q <= i2crb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // byte complete pulse on every address, received and transmitted byte
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bc_q <= 1'b0;
    end else begin
      bc_q <= byte_done || ((state_q == i2crb_pkg::ST_TX_ACK) && rise && i_enable);
    end
  end

  // slave busy: set on hardware match, cleared by Stop or disable
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
    end else if (addr_done && i_hw_address_compare_enable && addr_match) begin
      busy_q <= 1'b1;
    end else if (stop || !i_enable) begin
      busy_q <= 1'b0;
    end
  end

  // master base and current pointers
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_q <= i2crb_pkg::BASE_RST;
      cur_q  <= i2crb_pkg::CUR_RST;
    end else if (fetch_addr) begin
      cur_q  <= {1'b0, base_q} + 6'h01;
    end else if (addr_done) begin
      cur_q  <= {1'b0, base_q};
    end else if (byte_done && !is_addr_q && i_ram_buffer_mode && first_q) begin
      if (rx_byte <= i2crb_pkg::PTR_MAX) begin
        base_q <= rx_byte[4:0];
        cur_q  <= {1'b0, rx_byte[4:0]};
      end
    end else if ((store_byte || fetch_next) && !cur_q[5]) begin
      cur_q  <= cur_q + 6'h01;
    end
  end

  // master side buffer requests, one-cycle strobes
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mif.m_req   <= 1'b0;
      mif.m_we    <= 1'b0;
      mif.m_addr  <= i2crb_pkg::BASE_RST;
      mif.m_wdata <= i2crb_pkg::BYTE_RST;
      oor_q       <= 1'b0;
    end else begin
      mif.m_req <= 1'b0;
      if (store_byte) begin
        mif.m_req   <= 1'b1;
        mif.m_we    <= 1'b1;
        mif.m_addr  <= cur_q[4:0];
        mif.m_wdata <= rx_byte;
      end else if (fetch_addr) begin
        mif.m_req  <= 1'b1;
        mif.m_we   <= 1'b0;
        mif.m_addr <= base_q;
        oor_q      <= 1'b0;
      end else if (fetch_next) begin
        mif.m_req  <= !cur_q[5];
        mif.m_we   <= 1'b0;
        mif.m_addr <= cur_q[4:0];
        oor_q      <= cur_q[5];
      end
    end
  end

  // processor side: own pointer, independent of the master pointers
  assign cpu_access      = (i_cpu_buf_wr || i_cpu_buf_rd) && mif.c_ready;
  assign mif.c_req       = cpu_access;
  assign mif.c_we        = i_cpu_buf_wr;
  assign mif.c_addr      = cpu_cur_q;
  assign mif.c_wdata     = i_cpu_buf_wdata;
  assign o_cpu_buf_rdata = mif.c_rdata;
  assign o_cpu_buf_done  = mif.c_done;
  assign o_cpu_buf_ready = mif.c_ready;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cpu_cur_q <= i2crb_pkg::BASE_RST;
    end else if (i_cpu_base_wr) begin
      cpu_cur_q <= i_cpu_base_pointer;
    end else if (cpu_access) begin
      cpu_cur_q <= cpu_cur_q + 5'h01;
    end
  end

endmodule : i2crb_slave

// ### bench/i2crb_chk.sv
// Purpose: port checks for the two-wire slave
// Assumes: one clock domain
// Notes: bound onto the slave
`timescale 1ns/1ps
module i2crb_chk (
  input wire logic       i_clk_sys, i_sys_rst, i_scl, i_sda, i_enable, i_ram_buffer_mode,
  input wire logic       i_sleep, i_cpu_buf_rd, i_cpu_buf_wr, o_scl_oe, o_sda_oe,
  input wire logic       o_pins_claimed, o_byte_complete, o_slave_busy, o_rx_is_address,
  input wire logic       o_cpu_buf_done, o_cpu_buf_ready,
  input wire logic [6:0] i_slave_address,
  input wire logic [7:0] o_rx_data
);
  // all checks on the system clock, off in reset
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_pins_owned: assert property (o_pins_claimed == i_enable) else $error("pin claim");
  a_no_stretch: assert property (i_ram_buffer_mode && !i_sleep && o_slave_busy
    |-> !o_scl_oe) else $error("scl held");
  a_bc_single: assert property (o_byte_complete |=> !o_byte_complete) else $error("bc");
  a_sda_scl_low: assert property (i_enable && $changed(o_sda_oe) |-> !i_scl)
    else $error("sda moved with scl high");
  a_mismatch_nack: assert property (o_byte_complete && o_rx_is_address
    && o_rx_data[7:1] != i_slave_address |=> !o_sda_oe [*8]) else $error("mismatch acked");
  a_busy_match: assert property ($rose(o_slave_busy) |-> o_rx_is_address
    && o_rx_data[7:1] == i_slave_address) else $error("busy without match");
  a_busy_stop: assert property (o_slave_busy && i_scl && $rose(i_sda)
    |-> ##[1:8] !o_slave_busy) else $error("busy after stop");
  a_buf_answer: assert property ((i_cpu_buf_rd || i_cpu_buf_wr) && o_cpu_buf_ready
    |-> ##[1:2] o_cpu_buf_done) else $error("no done");
  a_ready_back: assert property (!o_cpu_buf_ready |=> o_cpu_buf_ready) else $error("rdy");
endmodule : i2crb_chk
bind i2crb_slave i2crb_chk i_i2crb_chk (.*);

// ### bench/i2crb_mst.sv
// Purpose: two-wire bus master model
// Assumes: 175 ns bit time, lines pulled up
// Notes: an output high pulls its line low
`timescale 1ns/1ps
module i2crb_mst (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  // count of bits where a stretching slave never let scl go
  int hung = 0;
  // lines released at time zero
  initial {o_scl_low, o_sda_low} = 2'b00;
  // start or restart, sda falls with scl high
  task automatic start();
    o_sda_low = 1'b0;
    #50 o_scl_low = 1'b0;
    #50 o_sda_low = 1'b1;
    #50 o_scl_low = 1'b1;
  endtask : start
  // nine bits msb first, last is the acknowledge slot
  task automatic xb(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #25 o_sda_low = !d[i];
      #100 o_scl_low = 1'b0;
      // follow a slave that holds scl low, bounded
      for (int w = 0; w < 400 && i_scl !== 1'b1; w++) #25;
      if (i_scl !== 1'b1) hung++;
      #15 r[i] = i_sda;
      #35 o_scl_low = 1'b1;
    end
  endtask : xb
  // stop, sda rises with scl high
  task automatic stop();
    #25 o_sda_low = 1'b1;
    #75 o_scl_low = 1'b0;
    #50 o_sda_low = 1'b0;
  endtask : stop
endmodule : i2crb_mst

// ### bench/tb_top.sv
// Purpose: self-checking bench for the slave in buffered mode, then compatible mode
// Assumes: hardware compare on, master model on the link
// Notes: reference buffer is an int array
`timescale 1ns/1ps
module tb_top;
  logic       clk, rst, sl, dl, so, dz, dn, rdy, bw, cw, cr, nck, ram, rel, stl;
  logic [4:0] bp;
  logic [6:0] sa;
  logic [7:0] wd, rd, txd, rxd;
  logic [8:0] r;
  int         fail_count, checks, seed, p, d, mdl [32];
  wire        scl = !(sl | so);
  wire        sda = !(dl | dz);
  i2crb_slave i_i2crb_slave (.i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_scl_o(), .o_scl_oe(so), .o_sda_o(), .o_sda_oe(dz), .o_pins_claimed(), .i_enable(1'b1),
    .i_ram_buffer_mode(ram), .i_hw_address_compare_enable(1'b1), .i_sleep(1'b0),
    .i_slave_address(sa), .o_byte_complete(), .o_rx_data(rxd), .o_rx_is_address(),
    .o_stalled(stl), .o_dir(), .o_slave_busy(), .i_cpu_release(rel), .i_cpu_nack(nck),
    .i_cpu_tx_data(txd),
    .i_cpu_base_wr(bw), .i_cpu_base_pointer(bp), .i_cpu_buf_wr(cw), .i_cpu_buf_rd(cr),
    .i_cpu_buf_wdata(wd), .o_cpu_buf_rdata(rd), .o_cpu_buf_done(dn), .o_cpu_buf_ready(rdy));
  i2crb_mst i_i2crb_mst (.i_scl(scl), .i_sda(sda), .o_scl_low(sl), .o_sda_low(dl));
  // system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // verdict
  task automatic test_done();
    fail_count += i_i2crb_mst.hung;
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // processor pointer load
  task automatic setbp(input logic [4:0] b);
    @(posedge clk);
    bp <= b;
    bw <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
  endtask : setbp
  // processor access, held past a busy cycle, bounded wait for done
  task automatic cpu(input logic w, input logic [7:0] v);
    @(posedge clk);
    cw <= w;
    cr <= !w;
    wd <= v;
    @(negedge clk);
    if (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    cw <= 1'b0;
    cr <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(negedge clk);
      if (dn === 1'b1) return;
    end
    fail_count++;
    test_done();
  endtask : cpu
  // master byte with expected acknowledge, x skips it
  task automatic wb(input logic [7:0] v, input logic a);
    i_i2crb_mst.xb({v, 1'b1}, r);
    if (a !== 1'bx) chk({7'h00, r[0]}, {7'h00, a});
  endtask : wb
  // buffered-mode scenarios
  initial begin
    rst = 1'b1;
    seed = 71;
    {cw, cr, bw, bp, wd, nck, txd, rel} = '0;
    ram = 1'b1;
    sa = 7'($random(seed));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    setbp(5'h00);
    for (int i = 0; i < 32; i++) begin
      mdl[i] = $random(seed) & 255;
      cpu(1'b1, 8'(mdl[i]));
    end
    for (int k = 0; k < 3; k++) begin
      p = k ? 16 + ($random(seed) & 15) : 30;
      txd <= 8'($random(seed));
      nck <= 1'($random(seed));
      fork
        begin
          i_i2crb_mst.start();
          wb({sa, 1'b0}, 1'b0);
          wb(8'(p), 1'b0);
          for (int j = 0; j < 3; j++) begin
            d = $random(seed) & 255;
            wb(8'(d), p + j < 32 ? 1'b0 : 1'bx);
            if (p + j < 32) mdl[p + j] = d;
          end
          i_i2crb_mst.stop();
        end
        begin
          setbp(5'h00);
          #4500;
          for (int i = 0; i < 32; i++) begin
            if (i % 16 == 0) setbp(5'h00);
            mdl[i % 16] = i * 3 + k;
            cpu(1'b1, 8'(mdl[i % 16]));
          end
        end
      join
      i_i2crb_mst.start();
      wb({sa, 1'b0}, 1'b0);
      wb(8'h20 | 8'(p), 1'b1);
      i_i2crb_mst.stop();
      i_i2crb_mst.start();
      wb({sa ^ 7'h01, 1'b0}, 1'b1);
      i_i2crb_mst.start();
      wb({sa, 1'b1}, 1'b0);
      for (int j = 0; j < 3; j++) begin
        i_i2crb_mst.xb({8'hFF, j == 2}, r);
        if (p + j < 32) chk(r[8:1], 8'(mdl[p + j]));
      end
      i_i2crb_mst.stop();
      setbp(5'h10);
      for (int i = 0; i < 32; i++) begin
        cpu(1'b0, 8'h00);
        chk(rd, 8'(mdl[(i + 16) % 32]));
      end
      $display("pass %0d done", k);
    end
    // compatible mode: a data byte stalls the bus until the processor answers
    @(posedge clk);
    ram <= 1'b0;
    @(negedge clk);
    fork
      begin
        i_i2crb_mst.start();
        wb({sa, 1'b0}, 1'b0);
        wb(8'h5A, 1'b0);
        i_i2crb_mst.stop();
      end
      begin
        for (int n = 0; n < 4000 && so !== 1'b1; n++) @(negedge clk);
        chk({6'h00, stl, so}, 8'h03);
        chk(rxd, 8'h5A);
        @(posedge clk);
        rel <= 1'b1;
        nck <= 1'b0;
        @(posedge clk);
        rel <= 1'b0;
      end
    join
    $display("compat done");
    test_done();
  end
endmodule : tb_top
